// ---- verilog/return_address_stack_regs.vh ----
// Register offsets, field positions and reset values of the return stack
`ifndef RETURN_ADDRESS_STACK_REGS_VH
`define RETURN_ADDRESS_STACK_REGS_VH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define PC_W 21
`define POS_W 5
`define ADDR_W 8
`define DEPTH 32

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_STATUS 8'h00
`define OFF_TOP_LOW 8'h04
`define OFF_TOP_HIGH 8'h08
`define OFF_TOP_UPPER 8'h0c
`define OFF_CFG 8'h10
`define OFF_IRQ_STATUS 8'h14
`define OFF_IRQ_CLEAR 8'h18
`define OFF_IRQ_ENABLE 8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_FULL 7
`define BIT_UNF 6
`define BIT_FAULT_RST_EN 0
`define BIT_EV_FULL 0
`define BIT_EV_UNF 1

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define POS_TOP 5'h1f
`define POS_NEAR_TOP 5'h1e
`define POS_EMPTY 5'h00
`define CFG_RST 1'h0
`define IRQ_RST 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verilog/stack_storage.v ----
// Flip-flop storage of the return stack entries
`timescale 1ns/1ps
`include "return_address_stack_regs.vh"

module stack_storage (
  input wire clk,
  input wire rst_n,
  input wire we,
  input wire [`POS_W-1:0] wr_idx,
  input wire [`PC_W-1:0] wr_data,
  input wire [2:0] wr_mask,
  input wire [`POS_W-1:0] rd_idx,
  output wire [`PC_W-1:0] rd_data
);

  reg [`PC_W-1:0] entry_r [0:`DEPTH-1];
  integer i;

  assign rd_data = entry_r[rd_idx];

  // ----------------------------------------------------------------------
  // Write port, byte lanes low, high, upper
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < `DEPTH; i = i + 1) begin
        entry_r[i] <= {`PC_W{1'b0}};
      end
    end else if (we) begin
      if (wr_mask[0]) begin
        entry_r[wr_idx][7:0] <= wr_data[7:0];
      end
      if (wr_mask[1]) begin
        entry_r[wr_idx][15:8] <= wr_data[15:8];
      end
      if (wr_mask[2]) begin
        entry_r[wr_idx][20:16] <= wr_data[20:16];
      end
    end
  end

endmodule // stack_storage

// ---- verilog/axil_write_capture.v ----
// AXI4-Lite write address and data capture, either order
`timescale 1ns/1ps
`include "return_address_stack_regs.vh"

module axil_write_capture (
  input wire clk,
  input wire rst_n,
  input wire [`ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  input wire consume,
  output wire have_both,
  output reg [`ADDR_W-1:0] addr_q,
  output reg [31:0] data_q,
  output reg [3:0] strb_q
);

  reg awready_r;
  reg wready_r;

  assign awready = awready_r;
  assign wready = wready_r;
  // Both halves held once neither ready is up
  assign have_both = !awready_r && !wready_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      addr_q <= {`ADDR_W{1'b0}};
      data_q <= 32'h00000000;
      strb_q <= 4'h0;
    end else begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        addr_q <= awaddr;
      end
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        data_q <= wdata;
        strb_q <= wstrb;
      end
      if (consume) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

endmodule // axil_write_capture

// ---- verilog/return_address_stack.v ----
// Return address stack with pointer status, top entry access and AXI4-Lite
`timescale 1ns/1ps
`include "return_address_stack_regs.vh"

// Summary of operation
// - Every stack entry holds a full 21-bit program counter value.
// - Pointer bits 4..0 hold stack position, read/write, reset to zero.
// - Full or overflow, and underflow, each set their own sticky flag.
// - Flags in bits 7 and 6 clear only by software write or reset.
// - Explicit push increments pointer and stores current PC at new top.
// - Top entry is readable and writable as low, high and upper bytes.
// - Explicit pop decrements pointer; previous entry becomes top.
// - With fault reset disabled, full or underflow only sets its flag.
// - With fault reset enabled, flag and device reset request rise together.
module return_address_stack (
  input wire clk,
  input wire rst_n,
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [`PC_W-1:0] pc_in,
  input wire push_req,
  input wire pop_req,
  input wire call_push,
  input wire ret_pop,
  output reg [`PC_W-1:0] ret_pc,
  output reg ret_valid,
  output reg [`PC_W-1:0] top_entry,
  output reg device_reset_req,
  output reg irq
);

  // ----------------------------------------------------------------------
  // Register selection codes
  // ----------------------------------------------------------------------
  localparam SEL_NONE = 4'h0;
  localparam SEL_STATUS = 4'h1;
  localparam SEL_TOP_LOW = 4'h2;
  localparam SEL_TOP_HIGH = 4'h3;
  localparam SEL_TOP_UPPER = 4'h4;
  localparam SEL_CFG = 4'h5;
  localparam SEL_IRQ_STATUS = 4'h6;
  localparam SEL_IRQ_CLEAR = 4'h7;
  localparam SEL_IRQ_ENABLE = 4'h8;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function [3:0] reg_sel;
    input [`ADDR_W-1:0] addr;
    begin
      case (addr)
        `OFF_STATUS: reg_sel = SEL_STATUS;
        `OFF_TOP_LOW: reg_sel = SEL_TOP_LOW;
        `OFF_TOP_HIGH: reg_sel = SEL_TOP_HIGH;
        `OFF_TOP_UPPER: reg_sel = SEL_TOP_UPPER;
        `OFF_CFG: reg_sel = SEL_CFG;
        `OFF_IRQ_STATUS: reg_sel = SEL_IRQ_STATUS;
        `OFF_IRQ_CLEAR: reg_sel = SEL_IRQ_CLEAR;
        `OFF_IRQ_ENABLE: reg_sel = SEL_IRQ_ENABLE;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  function [`POS_W-1:0] pos_step;
    input [`POS_W-1:0] pos;
    input up;
    begin
      if (up) begin
        pos_step = pos + 5'h01;
      end else begin
        pos_step = pos - 5'h01;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [`POS_W-1:0] position_r;
  reg [`POS_W-1:0] position_nxt;
  reg full_flag_r;
  reg full_flag_nxt;
  reg unf_flag_r;
  reg unf_flag_nxt;
  reg fault_rst_en_r;
  reg fault_rst_en_nxt;
  reg [1:0] ev_status_r;
  reg [1:0] ev_status_nxt;
  reg [1:0] ev_enable_r;
  reg [1:0] ev_enable_nxt;
  reg [`PC_W-1:0] wr_data;
  reg [2:0] wr_mask;
  reg [`POS_W-1:0] wr_idx;
  reg wr_en;
  reg [31:0] rd_word;
  reg [1:0] rd_resp;

  wire wr_both;
  wire [`ADDR_W-1:0] wr_addr_q;
  wire [31:0] wr_data_q;
  wire [3:0] wr_strb_q;
  wire [`PC_W-1:0] top_rd;
  wire push_any;
  wire pop_any;
  wire core_op;
  wire full_ev;
  wire unf_ev;
  wire wr_go;
  wire [3:0] wsel;
  wire [3:0] rsel;
  wire lane0;

  // ----------------------------------------------------------------------
  // Core sequencer requests
  // ----------------------------------------------------------------------
  // Push wins if the sequencer ever raises both in one cycle
  assign push_any = push_req || call_push;
  assign pop_any = (pop_req || ret_pop) && !push_any;
  assign core_op = push_any || pop_any;

  // Level 30 push makes it full, level 31 push overflows
  assign full_ev = push_any && (position_r >= `POS_NEAR_TOP);
  assign unf_ev = pop_any && (position_r == `POS_EMPTY);

  // Software write waits while the core touches the stack, so none is lost
  assign wr_go = wr_both && !s_axi_bvalid && !core_op;
  assign wsel = reg_sel(wr_addr_q);
  assign rsel = reg_sel(s_axi_araddr);
  assign lane0 = wr_strb_q[0];

  // ----------------------------------------------------------------------
  // Sub blocks
  // ----------------------------------------------------------------------
  axil_write_capture u_wcap (
    .clk(clk),
    .rst_n(rst_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .consume(wr_go),
    .have_both(wr_both),
    .addr_q(wr_addr_q),
    .data_q(wr_data_q),
    .strb_q(wr_strb_q)
  );

  stack_storage u_store (
    .clk(clk),
    .rst_n(rst_n),
    .we(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_mask(wr_mask),
    .rd_idx(position_r),
    .rd_data(top_rd)
  );

  // ----------------------------------------------------------------------
  // Pointer, flags and entry writes
  // ----------------------------------------------------------------------
  always @* begin
    position_nxt = position_r;
    full_flag_nxt = full_flag_r;
    unf_flag_nxt = unf_flag_r;
    fault_rst_en_nxt = fault_rst_en_r;
    ev_status_nxt = ev_status_r;
    ev_enable_nxt = ev_enable_r;
    wr_en = 1'b0;
    wr_idx = position_r;
    wr_data = pc_in;
    wr_mask = 3'h7;
    if (wr_go && lane0) begin
      case (wsel)
        SEL_STATUS: begin
          position_nxt = wr_data_q[`POS_W-1:0];
          // Writing zero clears a flag, writing one leaves it
          if (!wr_data_q[`BIT_FULL]) begin
            full_flag_nxt = 1'b0;
          end
          if (!wr_data_q[`BIT_UNF]) begin
            unf_flag_nxt = 1'b0;
          end
        end
        SEL_TOP_LOW: begin
          wr_en = 1'b1;
          wr_data = {13'h0000, wr_data_q[7:0]};
          wr_mask = 3'h1;
        end
        SEL_TOP_HIGH: begin
          wr_en = 1'b1;
          wr_data = {5'h00, wr_data_q[7:0], 8'h00};
          wr_mask = 3'h2;
        end
        SEL_TOP_UPPER: begin
          wr_en = 1'b1;
          wr_data = {wr_data_q[4:0], 16'h0000};
          wr_mask = 3'h4;
        end
        SEL_CFG: begin
          fault_rst_en_nxt = wr_data_q[`BIT_FAULT_RST_EN];
        end
        SEL_IRQ_CLEAR: begin
          ev_status_nxt = ev_status_r & ~wr_data_q[1:0];
        end
        SEL_IRQ_ENABLE: begin
          ev_enable_nxt = wr_data_q[1:0];
        end
        default: begin
          position_nxt = position_r;
        end
      endcase
    end
    if (push_any && (position_r != `POS_TOP)) begin
      position_nxt = pos_step(position_r, 1'b1);
      wr_en = 1'b1;
      wr_idx = pos_step(position_r, 1'b1);
      wr_data = pc_in;
      wr_mask = 3'h7;
    end
    if (pop_any && (position_r != `POS_EMPTY)) begin
      position_nxt = pos_step(position_r, 1'b0);
    end
    // Set wins over any clear in the same cycle
    if (full_ev) begin
      full_flag_nxt = 1'b1;
      ev_status_nxt[`BIT_EV_FULL] = 1'b1;
    end
    if (unf_ev) begin
      unf_flag_nxt = 1'b1;
      ev_status_nxt[`BIT_EV_UNF] = 1'b1;
    end
    // Fault reset empties the stack; flags survive it
    if (device_reset_req) begin
      position_nxt = `POS_EMPTY;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      position_r <= `POS_EMPTY;
      full_flag_r <= 1'b0;
      unf_flag_r <= 1'b0;
      fault_rst_en_r <= `CFG_RST;
      ev_status_r <= `IRQ_RST;
      ev_enable_r <= `IRQ_RST;
    end else begin
      position_r <= position_nxt;
      full_flag_r <= full_flag_nxt;
      unf_flag_r <= unf_flag_nxt;
      fault_rst_en_r <= fault_rst_en_nxt;
      ev_status_r <= ev_status_nxt;
      ev_enable_r <= ev_enable_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Core side outputs
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      ret_pc <= {`PC_W{1'b0}};
      ret_valid <= 1'b0;
      top_entry <= {`PC_W{1'b0}};
      device_reset_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      ret_valid <= ret_pop && !push_any;
      if (ret_pop && !push_any) begin
        // An empty stack returns to address zero
        if (position_r == `POS_EMPTY) begin
          ret_pc <= {`PC_W{1'b0}};
        end else begin
          ret_pc <= top_rd;
        end
      end
      // Lags the pointer by one cycle
      top_entry <= top_rd;
      // Reset rises with the flag, one cycle after the event, only when enabled
      device_reset_req <= fault_rst_en_r &&
                          (full_ev || unf_ev);
      irq <= |(ev_status_nxt & ev_enable_nxt);
    end
  end

  // ----------------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (wsel == SEL_NONE) begin
        s_axi_bresp <= `RESP_SLVERR;
      end else begin
        s_axi_bresp <= `RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `RESP_OKAY;
    case (rsel)
      SEL_STATUS: begin
        rd_word = {24'h000000, full_flag_r, unf_flag_r, 1'b0,
                   position_r};
      end
      SEL_TOP_LOW: begin
        rd_word = {24'h000000, top_rd[7:0]};
      end
      SEL_TOP_HIGH: begin
        rd_word = {24'h000000, top_rd[15:8]};
      end
      SEL_TOP_UPPER: begin
        rd_word = {27'h0000000, top_rd[20:16]};
      end
      SEL_CFG: begin
        rd_word = {31'h00000000, fault_rst_en_r};
      end
      SEL_IRQ_STATUS: begin
        rd_word = {30'h00000000, ev_status_r};
      end
      SEL_IRQ_CLEAR: begin
        rd_word = 32'h00000000;
      end
      SEL_IRQ_ENABLE: begin
        rd_word = {30'h00000000, ev_enable_r};
      end
      default: begin
        rd_resp = `RESP_SLVERR;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // return_address_stack

// ---- tb/return_address_stack_props.sv ----
// Port-level assertions for the return address stack
`timescale 1ns/1ps
`include "return_address_stack_regs.vh"

module return_address_stack_props (
  input wire clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire push_req,
  input wire pop_req,
  input wire call_push,
  input wire ret_pop,
  input wire ret_valid,
  input wire device_reset_req
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ret_answer: assert property (ret_pop |=> ret_valid)
    else $error("return pop gave no answer");
  a_ret_cause: assert property (ret_valid |-> $past(ret_pop))
    else $error("return answer without a return pop");
  a_fault_cause: assert property (device_reset_req |->
    $past(push_req) || $past(call_push) || $past(pop_req) ||
    $past(ret_pop))
    else $error("device reset without a stack operation");
  a_status_pad: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == `OFF_STATUS |=> s_axi_rdata[31:8] == 24'h0 &&
    !s_axi_rdata[5])
    else $error("status read shows bits outside its fields");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready)
    else $error("second write address taken too early");
  a_resp_readys: assert property ($rose(s_axi_bvalid) |->
    !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write response while a channel is open");
endmodule // return_address_stack_props

bind return_address_stack return_address_stack_props u_props (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .push_req(push_req), .pop_req(pop_req),
  .call_push(call_push), .ret_pop(ret_pop), .ret_valid(ret_valid),
  .device_reset_req(device_reset_req));

// ---- tb/core_sequencer_model.sv ----
// Model of the core sequencer that pushes and pops return addresses
`timescale 1ns/1ps
`include "return_address_stack_regs.vh"

module core_sequencer_model (
  input wire clk,
  output logic [`PC_W-1:0] pc_in,
  output logic push_req,
  output logic pop_req,
  output logic call_push,
  output logic ret_pop
);
  initial begin
    pc_in = 21'h0;
    push_req = 1'b0;
    pop_req = 1'b0;
    call_push = 1'b0;
    ret_pop = 1'b0;
  end

  // Kinds: 0 push, 1 call, 2 pop, 3 return; one-cycle pulse each
  task automatic op(input logic [1:0] k, input logic [`PC_W-1:0] pc);
    @(posedge clk);
    pc_in <= pc;
    push_req <= (k == 2'h0);
    call_push <= (k == 2'h1);
    pop_req <= (k == 2'h2);
    ret_pop <= (k == 2'h3);
    @(posedge clk);
    push_req <= 1'b0;
    call_push <= 1'b0;
    pop_req <= 1'b0;
    ret_pop <= 1'b0;
    // PC moves on, so a late sample picks up a wrong value
    pc_in <= ~pc;
  endtask
endmodule // core_sequencer_model

// ---- tb/test_return_address_stack.sv ----
// Self-checking bench for the return address stack
`timescale 1ns/1ps
`include "return_address_stack_regs.vh"

module test_return_address_stack;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, ret_valid, dev_rst, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [20:0] pc_in, ret_pc, top_entry;
  wire push_req, pop_req, call_push, ret_pop;
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  logic [20:0] pq[$];
  logic [20:0] v[0:3];
  int miscompares = 0, comparisons = 0, rst_seen = 0;

  return_address_stack u_return_address_stack (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pc_in(pc_in),
    .push_req(push_req), .pop_req(pop_req), .call_push(call_push),
    .ret_pop(ret_pop), .ret_pc(ret_pc), .ret_valid(ret_valid),
    .top_entry(top_entry), .device_reset_req(dev_rst), .irq(irq));

  core_sequencer_model u_core_sequencer_model (.clk(clk), .pc_in(pc_in),
    .push_req(push_req), .pop_req(pop_req), .call_push(call_push),
    .ret_pop(ret_pop));

  always #5 clk = ~clk;

  // ----------------
  // Checking helpers
  // ----------------
  task automatic chk(input string what, input logic [33:0] e,
                     input logic [33:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic hang;
    chk("handshake", 34'h1, 34'h0);
    wrap_up();
  endtask

  // Results are compared where they appear, oldest note first
  always @(posedge clk) begin
    if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", wq.pop_front(), bresp);
    if (ret_valid) chk("ret_pc", pq.pop_front(), ret_pc);
    if (dev_rst) rst_seen++;
  end

  // ---------
  // Bus tasks
  // ---------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    @(posedge clk);
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    if (n >= 200) hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = `RESP_OKAY);
    int n;
    @(posedge clk);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    if (n >= 200) hang();
  endtask

  // --------------
  // Main sequence
  // --------------
  initial begin
    void'($urandom(79222));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0);
    rd(8'h20, 32'h0, `RESP_SLVERR);
    wr(8'h24, 32'h1, `RESP_SLVERR);
    for (int i = 0; i < 4; i++) v[i] = 21'($urandom);
    for (int i = 0; i < 3; i++) begin
      u_core_sequencer_model.op((i == 1) ? 2'h1 : 2'h0, v[i]);
    end
    rd(`OFF_STATUS, 32'h3);
    chk("top_entry", {13'h0, v[2]}, top_entry);
    rd(`OFF_TOP_LOW, {24'h0, v[2][7:0]});
    rd(`OFF_TOP_HIGH, {24'h0, v[2][15:8]});
    rd(`OFF_TOP_UPPER, {27'h0, v[2][20:16]});
    wr(`OFF_TOP_LOW, {24'h0, v[3][7:0]}, `RESP_OKAY);
    wr(`OFF_TOP_HIGH, {24'h0, v[3][15:8]}, `RESP_OKAY);
    wr(`OFF_TOP_UPPER, {27'h0, v[3][20:16]}, `RESP_OKAY);
    pq.push_back(v[3]);
    u_core_sequencer_model.op(2'h3, 21'h0);
    u_core_sequencer_model.op(2'h2, 21'h0);
    rd(`OFF_STATUS, 32'h1);
    pq.push_back(v[0]);
    u_core_sequencer_model.op(2'h3, 21'h0);
    pq.push_back(21'h0);
    u_core_sequencer_model.op(2'h3, 21'h0);
    u_core_sequencer_model.op(2'h2, 21'h0);
    rd(`OFF_STATUS, 32'h40);
    wr(`OFF_STATUS, 32'h5d, `RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      u_core_sequencer_model.op(2'h0, v[i]);
    end
    rd(`OFF_STATUS, 32'hdf);
    rd(`OFF_TOP_LOW, {24'h0, v[1][7:0]});
    chk("fault resets", 34'h0, rst_seen);
    wr(`OFF_IRQ_ENABLE, 32'h2, `RESP_OKAY);
    rd(`OFF_IRQ_STATUS, 32'h3);
    chk("irq", 34'h1, irq);
    wr(`OFF_IRQ_CLEAR, 32'h3, `RESP_OKAY);
    rd(`OFF_IRQ_STATUS, 32'h0);
    chk("irq", 34'h0, irq);
    rd(`OFF_STATUS, 32'hdf);
    wr(`OFF_STATUS, 32'h1f, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h1f);
    wr(`OFF_CFG, 32'h1, `RESP_OKAY);
    wr(`OFF_STATUS, 32'h1e, `RESP_OKAY);
    u_core_sequencer_model.op(2'h1, v[2]);
    rd(`OFF_STATUS, 32'h80);
    chk("fault resets", 34'h1, rst_seen);
    wrap_up();
  end
endmodule // test_return_address_stack
